// [testbench/scic_target_model.sv]
// Behavioural SCSI target facing the initiator
module scic_target_model (
  // Clock
  input wire clock_i,
  // Bus levels
  input wire ack_n_i,
  input wire [7:0] db_n_i,
  // Target drive, active low: parity,SEL,IO,CD,MSG,REQ,BSY,RST,ACK,ATN
  output logic [9:0] pins_n_o,
  output logic [7:0] db_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins_n_o = 10'h3ff;
    db_n_o = 8'hff;
  end
  // Released lines return to the terminator level
  task automatic set_pins(input logic [9:0] asserted);
    @(posedge clock_i);
    pins_n_o <= ~asserted;
    db_n_o <= 8'hff;
  endtask
  // Phase is {io,cd,msg}; gap makes a slow target
  task automatic xfer(input logic [2:0] ph, input logic [7:0] tx, input int gap,
                      output logic [7:0] rx, output logic acked);
    int i;
    @(posedge clock_i);
    pins_n_o[6] <= 1'b0;
    pins_n_o[4:2] <= ~{ph[0], ph[1], ph[2]};
    if (ph[2]) begin
      db_n_o <= ~tx;
      pins_n_o[0] <= ^tx;
    end
    repeat (gap + 1) @(posedge clock_i);
    pins_n_o[5] <= 1'b0;
    acked = 1'b0;
    rx = 8'h00;
    // Waits at most 40 cycles for ACK, then releases REQ whether or not a byte was taken
    for (i = 0; i < 40 && !acked; i++) begin
      @(posedge clock_i);
      if (ack_n_i === 1'b0) begin
        acked = 1'b1;
        rx = ~db_n_i;
      end
    end
    pins_n_o[5] <= 1'b1;
    for (i = 0; i < 40 && ack_n_i !== 1'b1; i++)
      @(posedge clock_i);
    db_n_o <= 8'hff;
    pins_n_o[0] <= 1'b1;
  endtask
endmodule

// [testbench/scic_top_properties.sv]
// Port-level concurrent checks for the initiator top
module scic_top_properties (
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // APB and interrupt
  input wire psel_i,
  input wire penable_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire irq_o,
  // SCSI bus
  input wire req_n_i,
  input wire ack_n_o,
  input wire ack_oe_o,
  input wire [7:0] db_n_o,
  input wire dbp_n_o,
  input wire db_oe_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_rdy_one;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
  property p_rdy_lat;
    (psel_i && penable_i && !pready_o) |=> pready_o;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("access not answered next cycle");
  property p_err_rdy;
    pslverr_o |-> pready_o;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_zero;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
  property p_ack_cause;
    $rose(ack_oe_o) |-> $past(req_n_i) == 1'b0;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_hold;
    (ack_oe_o && !req_n_i) |=> ack_oe_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_ack_drop;
    (ack_oe_o && req_n_i) |=> !ack_oe_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held after request");
  property p_ack_low;
    ack_oe_o |-> !ack_n_o;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack driven high");
  property p_db_par;
    db_oe_o |-> (^{~db_n_o, ~dbp_n_o}) == 1'b1 && ack_oe_o;
  endproperty
  a_db_par: assert property (p_db_par) else $error("bad data parity or no ack");
  property p_rst;
    $rose(reset_n_i) |-> !pready_o && !irq_o && !ack_oe_o && !db_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  c_out: cover property (ack_oe_o && db_oe_o);
  c_in: cover property ($rose(ack_oe_o) && !db_oe_o);
  c_err: cover property (pslverr_o);
  c_irq: cover property (irq_o);
endmodule
bind scic_top scic_top_properties scic_top_properties_inst (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
  .req_n_i(req_n_i), .ack_n_o(ack_n_o), .ack_oe_o(ack_oe_o), .db_n_o(db_n_o),
  .dbp_n_o(dbp_n_o), .db_oe_o(db_oe_o));

// [testbench/testbench.sv]
// Self-checking bench for the initiator top over APB
`include "scic_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic tick_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o, ack_n_o, ack_oe_o, dbp_n_o, db_oe_o;
  wire [7:0] db_n_o;
  wire [9:0] tp_n;
  wire [7:0] tdb_n;
  // Open-collector bus: any driver pulls a line low
  wire ack_w = (ack_oe_o ? ack_n_o : 1'b1) & tp_n[8];
  wire [7:0] db_w = (db_oe_o ? db_n_o : 8'hff) & tdb_n;
  wire dbp_w = (db_oe_o ? dbp_n_o : 1'b1) & tp_n[0];
  int errors = 0;
  int total_checks = 0;
  int k;
  logic [3:0] tcnt = 4'h0;
  logic [31:0] rd;
  logic [7:0] rx;
  logic ack;
  logic perr;
  logic [3:0] bad [3] = '{4'h0, 4'h9, 4'hf};
  always #5 clock_i = ~clock_i;
  // Free-running timebase, one tick per 16 cycles
  always @(posedge clock_i) begin
    tcnt <= tcnt + 4'h1;
    tick_i <= (tcnt == 4'hf);
  end
  scic_top scic_top_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .tick_i(tick_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .sel_n_i(tp_n[1]), .io_n_i(tp_n[2]), .cd_n_i(tp_n[3]),
    .msg_n_i(tp_n[4]), .req_n_i(tp_n[5]), .bsy_n_i(tp_n[6]), .rst_n_i(tp_n[7]),
    .ack_n_i(ack_w), .atn_n_i(tp_n[9]), .db_n_i(db_w), .dbp_n_i(dbp_w),
    .ack_n_o(ack_n_o), .ack_oe_o(ack_oe_o), .db_n_o(db_n_o), .dbp_n_o(dbp_n_o),
    .db_oe_o(db_oe_o));
  scic_target_model scic_target_model_inst (.clock_i(clock_i), .ack_n_i(ack_w),
    .db_n_i(db_w), .pins_n_o(tp_n), .db_n_o(tdb_n));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20 && pready_o !== 1'b1; i++)
      @(posedge clock_i);
    if (i == 20) begin
      errors++;
      final_report();
    end
    rd = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic ins(input logic [3:0] i, input logic [3:0] op, input logic [31:0] p2);
    apb(1'b1, `SCIC_OFF_INSTR_IDX, {28'h0, i});
    apb(1'b1, `SCIC_OFF_INSTR_OP, {28'h0, op});
    apb(1'b1, `SCIC_OFF_INSTR_P1, 32'h0);
    apb(1'b1, `SCIC_OFF_INSTR_P2, p2);
  endtask
  task automatic start(input logic [31:0] w, input logic [31:0] ctl);
    apb(1'b1, `SCIC_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `SCIC_OFF_WAIT, w);
    apb(1'b1, `SCIC_OFF_CTRL, ctl);
  endtask
  task automatic wait_idle;
    int i;
    // Target lets go of BSY first: finish only returns once the bus is free
    scic_target_model_inst.set_pins(10'h000);
    rd = 32'h1;
    for (i = 0; i < 300 && rd[0] !== 1'b0; i++)
      apb(1'b0, `SCIC_OFF_CTRL, 32'h0);
    if (i == 300) begin
      errors++;
      final_report();
    end
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rdc(`SCIC_OFF_WAIT, `SCIC_WAIT_RST);
    rdc(`SCIC_OFF_IRQ_STAT, 32'h0);
    apb(1'b0, `SCIC_OFF_STAT_WORD, 32'h0);
    chk(rd & 32'hffff_03ff, 32'h0);
    rdc(8'h40, 32'h0);
    chk(perr, 32'h1);
    for (k = 0; k < 10; k++) begin
      scic_target_model_inst.set_pins(10'h001 << k);
      apb(1'b0, `SCIC_OFF_STAT_WORD, 32'h0);
      chk(rd & 32'h3ff, 32'h1 << k);
    end
    $display("test regs done");
    for (k = 0; k < 4; k++) begin
      apb(1'b1, `SCIC_OFF_BUF_IDX, k);
      apb(1'b1, `SCIC_OFF_BUF_DATA, 8'h11 * (k + 1));
    end
    ins(0, `SCIC_MOVE_LONG_OPCODE, 2);
    ins(1, `SCIC_XFER_HOLD_OPCODE, 2);
    ins(2, `SCIC_ADD_LONG_OPCODE, 1);
    ins(3, `SCIC_XFER_INC_OPCODE, 1);
    ins(4, `SCIC_NOOP_OPCODE, 0);
    ins(5, `SCIC_HALT_OPCODE, 0);
    scic_target_model_inst.set_pins(10'h040);
    start(200, 32'h1 << `SCIC_CTRL_RUN);
    for (k = 0; k < 3; k++) begin
      scic_target_model_inst.xfer(3'b000, 8'h00, 2 * k, rx, ack);
      chk(rx, k < 2 ? 8'h33 : 8'h44);
    end
    wait_idle();
    rdc(`SCIC_OFF_RESULT, `SCIC_SUCCESS_CODE);
    rdc(`SCIC_OFF_IRQ_STAT, 32'h1 << `SCIC_IRQ_LIST);
    start(200, 32'h1 << `SCIC_CTRL_FINISH);
    scic_target_model_inst.xfer(3'b110, 8'h02, 0, rx, ack);
    scic_target_model_inst.xfer(3'b111, 8'h5a, 3, rx, ack);
    wait_idle();
    rdc(`SCIC_OFF_RESULT, `SCIC_SUCCESS_CODE);
    rdc(`SCIC_OFF_FIN_STAT, 32'h02);
    rdc(`SCIC_OFF_FIN_MSG, 32'h5a);
    chk({ack_oe_o, db_oe_o}, 32'h0);
    rdc(`SCIC_OFF_IRQ_STAT, 32'h1 << `SCIC_IRQ_FIN);
    apb(1'b1, `SCIC_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 32'h0);
    apb(1'b1, `SCIC_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 32'h1);
    apb(1'b0, `SCIC_OFF_STAT_WORD, 32'h0);
    chk(rd & 32'h1000, 32'h1000);
    apb(1'b1, `SCIC_OFF_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 32'h0);
    $display("test write and finish done");
    start(200, 32'h1 << `SCIC_CTRL_FINISH);
    scic_target_model_inst.xfer(3'b100, 8'h33, 0, rx, ack);
    for (k = 0; k < 2; k++) begin
      scic_target_model_inst.xfer(3'b000, 8'h00, k, rx, ack);
      chk(rx, `SCIC_FILLER_BYTE);
    end
    scic_target_model_inst.xfer(3'b110, 8'h00, 0, rx, ack);
    scic_target_model_inst.xfer(3'b111, 8'h00, 0, rx, ack);
    wait_idle();
    rdc(`SCIC_OFF_RESULT, `SCIC_FINISH_RECOVERY_ERROR_CODE);
    start(200, 32'h1 << `SCIC_CTRL_FINISH);
    scic_target_model_inst.xfer(3'b011, 8'h00, 0, rx, ack);
    wait_idle();
    rdc(`SCIC_OFF_RESULT, `SCIC_PHASE_ERROR_CODE);
    apb(1'b0, `SCIC_OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    start(3, 32'h1 << `SCIC_CTRL_FINISH);
    apb(1'b0, `SCIC_OFF_CTRL, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wait_idle();
    rdc(`SCIC_OFF_RESULT, `SCIC_TIMEOUT_ERROR_CODE);
    $display("test finish recovery done");
    ins(1, `SCIC_XFER_INC_OPCODE, 1);
    for (k = 0; k < 3; k++) begin
      ins(0, bad[k], 0);
      start(3, 32'h1 << `SCIC_CTRL_RUN);
      wait_idle();
      rdc(`SCIC_OFF_RESULT, `SCIC_BAD_INSTRUCTION_ERROR_CODE);
    end
    ins(0, `SCIC_MOVE_LONG_OPCODE, 0);
    ins(1, `SCIC_XFER_INC_OPCODE, 2);
    ins(2, `SCIC_HALT_OPCODE, 0);
    // Second byte comes in a wrong phase: only the polled run notices
    for (k = 0; k < 2; k++) begin
      scic_target_model_inst.set_pins(10'h040);
      start(200, k ? 32'h3 : 32'h1);
      scic_target_model_inst.xfer(3'b000, 8'h00, 0, rx, ack);
      chk(rx, 8'h11);
      scic_target_model_inst.xfer(3'b010, 8'h00, 0, rx, ack);
      chk(ack, k);
      wait_idle();
      rdc(`SCIC_OFF_RESULT, k ? `SCIC_SUCCESS_CODE : `SCIC_PHASE_ERROR_CODE);
    end
    ins(1, `SCIC_LOOP_OPCODE, 1);
    ins(2, `SCIC_COMPARE_OPCODE, 1);
    ins(3, `SCIC_HALT_OPCODE, 0);
    for (k = 0; k < 2; k++) begin
      scic_target_model_inst.set_pins(10'h040);
      start(200, 32'h9);
      scic_target_model_inst.xfer(3'b100, k ? 8'h99 : 8'h11, 0, rx, ack);
      wait_idle();
      rdc(`SCIC_OFF_RESULT, k ? `SCIC_COMPARE_ERROR_CODE : `SCIC_SUCCESS_CODE);
    end
    $display("test list modes done");
    final_report();
  end
endmodule

// [verilog/scic_consts.vh]
// Register map, opcodes, result codes and bit positions of the initiator block
`ifndef SCIC_CONSTS_VH
`define SCIC_CONSTS_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SCIC_OFF_CTRL 8'h00
`define SCIC_OFF_STAT_WORD 8'h04
`define SCIC_OFF_RESULT 8'h08
`define SCIC_OFF_FIN_STAT 8'h0c
`define SCIC_OFF_FIN_MSG 8'h10
`define SCIC_OFF_WAIT 8'h14
`define SCIC_OFF_IRQ_STAT 8'h18
`define SCIC_OFF_IRQ_MASK 8'h1c
`define SCIC_OFF_INSTR_IDX 8'h20
`define SCIC_OFF_INSTR_OP 8'h24
`define SCIC_OFF_INSTR_P1 8'h28
`define SCIC_OFF_INSTR_P2 8'h2c
`define SCIC_OFF_BUF_IDX 8'h30
`define SCIC_OFF_BUF_DATA 8'h34
// ----------------------------------------------------------------------------
// Control bits, interrupt bits, reset values
// ----------------------------------------------------------------------------
`define SCIC_CTRL_RUN 0
`define SCIC_CTRL_BLIND 1
`define SCIC_CTRL_FINISH 2
`define SCIC_CTRL_READ 3
`define SCIC_IRQ_LIST 0
`define SCIC_IRQ_FIN 1
`define SCIC_IRQ_ERR 2
`define SCIC_IRQ_W 3
`define SCIC_WAIT_RST 32'h0000_0000
// ----------------------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------------------
`define SCIC_OP_W 4
`define SCIC_XFER_INC_OPCODE 4'h1
`define SCIC_XFER_HOLD_OPCODE 4'h2
`define SCIC_ADD_LONG_OPCODE 4'h3
`define SCIC_MOVE_LONG_OPCODE 4'h4
`define SCIC_LOOP_OPCODE 4'h5
`define SCIC_NOOP_OPCODE 4'h6
`define SCIC_HALT_OPCODE 4'h7
`define SCIC_COMPARE_OPCODE 4'h8
// ----------------------------------------------------------------------------
// Result codes
// ----------------------------------------------------------------------------
`define SCIC_SUCCESS_CODE 4'h0
`define SCIC_TIMEOUT_ERROR_CODE 4'h2
`define SCIC_BAD_INSTRUCTION_ERROR_CODE 4'h4
`define SCIC_PHASE_ERROR_CODE 4'h5
`define SCIC_COMPARE_ERROR_CODE 4'h6
`define SCIC_FINISH_RECOVERY_ERROR_CODE 4'ha
`define SCIC_FILLER_BYTE 8'hee
// ----------------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------------
`define SCIC_SW_BUS_W 10
`define SCIC_SW_CTL_W 6
`endif

// [verilog/scic_stat_word.v]
// Registered 16-bit bus and controller status word
`include "scic_consts.vh"
module scic_stat_word (
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // Sources: pins are active low, controller flags active high
  input wire [`SCIC_SW_BUS_W-1:0] bus_n_i,
  input wire [`SCIC_SW_CTL_W-1:0] ctl_i,
  // Word
  output reg [15:0] stat_o
);
  always @(posedge clock_i) begin
    if (!reset_n_i)
      stat_o <= 16'h0000;
    else
      stat_o <= {ctl_i, ~bus_n_i};
  end
endmodule

// [verilog/scic_tick_timer.v]
// Tick counter that flags a timeout once the programmed wait is reached
module scic_tick_timer #(
  parameter W = 32
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // Control
  input wire clear_i,
  input wire tick_i,
  input wire [W-1:0] limit_i,
  // Result
  output reg expired_o
);
  reg [W-1:0] cnt_r;

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt_r <= {W{1'b0}};
      expired_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= {W{1'b0}};
      expired_o <= 1'b0;
    end else begin
      if (tick_i && !expired_o)
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      expired_o <= (cnt_r >= limit_i);
    end
  end
endmodule

// [verilog/scic_top.v]
// SCSI initiator: instruction list engine, transaction finish and status word
//
// Decided for this implementation: the APB register port and the placing of the registers.
`include "scic_consts.vh"
module scic_top #(
  parameter INSTR_DEPTH = 8,
  parameter IW = 3,
  parameter BUF_DEPTH = 16,
  parameter BW = 4
) (
  // Clock, reset, timebase
  input wire clock_i,
  input wire reset_n_i,
  input wire tick_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Interrupt
  output reg irq_o,
  // SCSI bus, active low pins
  input wire sel_n_i,
  input wire io_n_i,
  input wire cd_n_i,
  input wire msg_n_i,
  input wire req_n_i,
  input wire bsy_n_i,
  input wire rst_n_i,
  input wire ack_n_i,
  input wire atn_n_i,
  input wire [7:0] db_n_i,
  input wire dbp_n_i,
  output reg ack_n_o,
  output reg ack_oe_o,
  output reg [7:0] db_n_o,
  output reg dbp_n_o,
  output reg db_oe_o
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function odd_par;
    input [7:0] d;
    odd_par = ~^d;
  endfunction

  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_ACK = 3'd3;
  localparam S_REL = 3'd4;

  wire io = ~io_n_i;
  wire cd = ~cd_n_i;
  wire msg = ~msg_n_i;
  wire req = ~req_n_i;
  wire bsy = ~bsy_n_i;
  wire [7:0] db_in = ~db_n_i;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [`SCIC_OP_W-1:0] iop_mem [0:INSTR_DEPTH-1];
  reg [31:0] ip1_mem [0:INSTR_DEPTH-1];
  reg [31:0] ip2_mem [0:INSTR_DEPTH-1];
  reg [7:0] buf_mem [0:BUF_DEPTH-1];
  reg [2:0] st_r;
  reg mode_fin_r;
  reg blind_r;
  reg dir_rd_r;
  reg first_r;
  reg recov_r;
  reg got_msg_r;
  reg busy_err_r;
  reg par_err_r;
  reg done_r;
  reg [IW-1:0] pc_r;
  reg [IW-1:0] iidx_r;
  reg [BW-1:0] ptr_r;
  reg [BW-1:0] bidx_r;
  reg [`SCIC_OP_W-1:0] xop_r;
  reg [31:0] cnt_r;
  reg [31:0] loop_r;
  reg loop_on_r;
  reg [3:0] result_r;
  reg [7:0] fin_stat_r;
  reg [7:0] fin_msg_r;
  reg [31:0] wait_r;
  reg [`SCIC_IRQ_W-1:0] irq_stat_r;
  reg [`SCIC_IRQ_W-1:0] irq_mask_r;
  reg [`SCIC_IRQ_W-1:0] irq_ev_r;
  wire tmr_exp;
  wire [15:0] stat_word;

  wire [`SCIC_OP_W-1:0] cur_op = iop_mem[pc_r];
  wire [31:0] cur_p1 = ip1_mem[pc_r];
  wire [31:0] cur_p2 = ip2_mem[pc_r];
  wire [31:0] loop_next = loop_on_r ? loop_r - 32'd1 : cur_p2 - 32'd1;
  wire ph_match = (io == dir_rd_r) && !cd && !msg;
  wire wr = psel_i && penable_i && pready_o && pwrite_i;
  wire run_go = wr && (paddr_i == `SCIC_OFF_CTRL) && pwdata_i[`SCIC_CTRL_RUN];
  wire fin_go = wr && (paddr_i == `SCIC_OFF_CTRL) && pwdata_i[`SCIC_CTRL_FINISH];
  // Blind mode keeps the timer running across bytes of one instruction
  wire tmr_clr = (st_r == S_IDLE) || (st_r == S_FETCH) ||
                 (st_r == S_ACK && !mode_fin_r && !blind_r);

  scic_tick_timer #(.W(32)) u_timer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .clear_i(tmr_clr),
    .tick_i(tick_i),
    .limit_i(wait_r),
    .expired_o(tmr_exp)
  );

  scic_stat_word u_stat (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .bus_n_i({atn_n_i, ack_n_i, rst_n_i, bsy_n_i, req_n_i, msg_n_i, cd_n_i,
              io_n_i, sel_n_i, dbp_n_i}),
    .ctl_i({done_r, req && ph_match && (st_r == S_WAIT), par_err_r, irq_o,
            ph_match, busy_err_r}),
    .stat_o(stat_word)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Enable and level of the open-drain ACK always move together
  task set_ack;
    input v;
    begin
      ack_oe_o <= v;
      ack_n_o <= ~v;
    end
  endtask

  // Events are registered here, so the status register sees them one cycle later
  task finish;
    input [3:0] code;
    begin
      result_r <= code;
      st_r <= S_IDLE;
      done_r <= 1'b1;
      set_ack(1'b0);
      db_oe_o <= 1'b0;
      irq_ev_r[mode_fin_r ? `SCIC_IRQ_FIN : `SCIC_IRQ_LIST] <= 1'b1;
      if (code != `SCIC_SUCCESS_CODE)
        irq_ev_r[`SCIC_IRQ_ERR] <= 1'b1;
    end
  endtask

  always @(posedge clock_i) begin
    irq_ev_r <= {`SCIC_IRQ_W{1'b0}};
    if (!reset_n_i) begin
      st_r <= S_IDLE;
      mode_fin_r <= 1'b0;
      blind_r <= 1'b0;
      dir_rd_r <= 1'b0;
      first_r <= 1'b0;
      recov_r <= 1'b0;
      got_msg_r <= 1'b0;
      busy_err_r <= 1'b0;
      par_err_r <= 1'b0;
      done_r <= 1'b0;
      pc_r <= {IW{1'b0}};
      ptr_r <= {BW{1'b0}};
      xop_r <= {`SCIC_OP_W{1'b0}};
      cnt_r <= 32'h0000_0000;
      loop_r <= 32'h0000_0000;
      loop_on_r <= 1'b0;
      result_r <= `SCIC_SUCCESS_CODE;
      fin_stat_r <= 8'h00;
      fin_msg_r <= 8'h00;
      db_n_o <= 8'hff;
      dbp_n_o <= 1'b1;
      db_oe_o <= 1'b0;
      set_ack(1'b0);
    end else begin
      case (st_r)
        S_IDLE: begin
          if (run_go || fin_go) begin
            mode_fin_r <= fin_go && !run_go;
            blind_r <= pwdata_i[`SCIC_CTRL_BLIND];
            dir_rd_r <= pwdata_i[`SCIC_CTRL_READ];
            st_r <= run_go ? S_FETCH : S_WAIT;
            pc_r <= {IW{1'b0}};
            loop_on_r <= 1'b0;
            recov_r <= 1'b0;
            got_msg_r <= 1'b0;
            busy_err_r <= 1'b0;
            par_err_r <= 1'b0;
            done_r <= 1'b0;
          end
        end
        S_FETCH: begin
          pc_r <= pc_r + {{(IW-1){1'b0}}, 1'b1};
          case (cur_op)
            `SCIC_XFER_INC_OPCODE, `SCIC_XFER_HOLD_OPCODE, `SCIC_COMPARE_OPCODE: begin
              xop_r <= cur_op;
              cnt_r <= cur_p2;
              first_r <= 1'b1;
              if (cur_p2 != 32'h0000_0000) begin
                pc_r <= pc_r;
                st_r <= S_WAIT;
              end
            end
            `SCIC_ADD_LONG_OPCODE: ptr_r <= ptr_r + cur_p2[BW-1:0];
            `SCIC_MOVE_LONG_OPCODE: ptr_r <= cur_p2[BW-1:0];
            `SCIC_LOOP_OPCODE: begin
              loop_r <= loop_next;
              loop_on_r <= (loop_next != 32'h0000_0000);
              if (loop_next != 32'h0000_0000)
                pc_r <= pc_r + cur_p1[IW-1:0];
            end
            `SCIC_NOOP_OPCODE: ;
            `SCIC_HALT_OPCODE: finish(`SCIC_SUCCESS_CODE);
            default: finish(`SCIC_BAD_INSTRUCTION_ERROR_CODE);
          endcase
        end
        S_WAIT: begin
          if (!mode_fin_r && !bsy)
            busy_err_r <= 1'b1;
          if (tmr_exp) begin
            finish(`SCIC_TIMEOUT_ERROR_CODE);
          end else if (req) begin
            if (io && (dbp_n_i == odd_par(db_in)))
              par_err_r <= 1'b1;
            if (mode_fin_r) begin
              if (!io && cd && msg) begin
                finish(`SCIC_PHASE_ERROR_CODE);
              end else begin
                st_r <= S_ACK;
                set_ack(1'b1);
                if (io && cd && !msg)
                  fin_stat_r <= db_in;
                else if (io && cd && msg) begin
                  fin_msg_r <= db_in;
                  got_msg_r <= 1'b1;
                end else
                  recov_r <= 1'b1;
                if (!io) begin
                  db_n_o <= ~`SCIC_FILLER_BYTE;
                  dbp_n_o <= ~odd_par(`SCIC_FILLER_BYTE);
                  db_oe_o <= 1'b1;
                end
              end
            end else if ((first_r || !blind_r) && !ph_match) begin
              finish(`SCIC_PHASE_ERROR_CODE);
            end else if (xop_r == `SCIC_COMPARE_OPCODE && db_in != buf_mem[ptr_r]) begin
              finish(`SCIC_COMPARE_ERROR_CODE);
            end else begin
              st_r <= S_ACK;
              set_ack(1'b1);
              if (!dir_rd_r) begin
                db_n_o <= ~buf_mem[ptr_r];
                dbp_n_o <= ~odd_par(buf_mem[ptr_r]);
                db_oe_o <= 1'b1;
              end
            end
          end
        end
        S_ACK: begin
          if (tmr_exp) begin
            finish(`SCIC_TIMEOUT_ERROR_CODE);
          end else if (!req) begin
            set_ack(1'b0);
            db_oe_o <= 1'b0;
            first_r <= 1'b0;
            if (mode_fin_r) begin
              st_r <= got_msg_r ? S_REL : S_WAIT;
            end else begin
              if (xop_r != `SCIC_XFER_HOLD_OPCODE)
                ptr_r <= ptr_r + {{(BW-1){1'b0}}, 1'b1};
              cnt_r <= cnt_r - 32'd1;
              if (cnt_r == 32'd1) begin
                pc_r <= pc_r + {{(IW-1){1'b0}}, 1'b1};
                st_r <= S_FETCH;
              end else
                st_r <= S_WAIT;
            end
          end
        end
        S_REL: begin
          if (tmr_exp)
            finish(`SCIC_TIMEOUT_ERROR_CODE);
          else if (!bsy)
            finish(recov_r ? `SCIC_FINISH_RECOVERY_ERROR_CODE
                           : `SCIC_SUCCESS_CODE);
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Inbound bytes of a read list land in the buffer when the phase matches, except those of a compare
  always @(posedge clock_i) begin
    if (st_r == S_WAIT && req && !mode_fin_r && dir_rd_r && ph_match &&
        xop_r != `SCIC_COMPARE_OPCODE)
      buf_mem[ptr_r] <= db_in;
    else if (wr && paddr_i == `SCIC_OFF_BUF_DATA)
      buf_mem[bidx_r] <= pwdata_i[7:0];
  end

  // --------------------------------------------------------------------------
  // APB registers
  // --------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (wr && paddr_i == `SCIC_OFF_INSTR_OP)
      iop_mem[iidx_r] <= pwdata_i[`SCIC_OP_W-1:0];
    if (wr && paddr_i == `SCIC_OFF_INSTR_P1)
      ip1_mem[iidx_r] <= pwdata_i;
    if (wr && paddr_i == `SCIC_OFF_INSTR_P2)
      ip2_mem[iidx_r] <= pwdata_i;
  end

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      wait_r <= `SCIC_WAIT_RST;
      irq_stat_r <= {`SCIC_IRQ_W{1'b0}};
      irq_mask_r <= {`SCIC_IRQ_W{1'b0}};
      irq_o <= 1'b0;
      iidx_r <= {IW{1'b0}};
      bidx_r <= {BW{1'b0}};
    end else begin
      // One wait state gives registered read data and a registered ready
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_o) begin
        case (paddr_i)
          `SCIC_OFF_CTRL: prdata_o <= {31'h0, st_r != S_IDLE};
          `SCIC_OFF_STAT_WORD: prdata_o <= {16'h0000, stat_word};
          `SCIC_OFF_RESULT: prdata_o <= {28'h0, result_r};
          `SCIC_OFF_FIN_STAT: prdata_o <= {24'h0, fin_stat_r};
          `SCIC_OFF_FIN_MSG: prdata_o <= {24'h0, fin_msg_r};
          `SCIC_OFF_WAIT: prdata_o <= wait_r;
          `SCIC_OFF_IRQ_STAT: prdata_o <= {29'h0, irq_stat_r};
          `SCIC_OFF_IRQ_MASK: prdata_o <= {29'h0, irq_mask_r};
          `SCIC_OFF_INSTR_IDX: prdata_o <= {{(32-IW){1'b0}}, iidx_r};
          `SCIC_OFF_INSTR_OP: prdata_o <= {28'h0, iop_mem[iidx_r]};
          `SCIC_OFF_INSTR_P1: prdata_o <= ip1_mem[iidx_r];
          `SCIC_OFF_INSTR_P2: prdata_o <= ip2_mem[iidx_r];
          `SCIC_OFF_BUF_IDX: prdata_o <= {{(32-BW){1'b0}}, bidx_r};
          `SCIC_OFF_BUF_DATA: prdata_o <= {24'h0, buf_mem[bidx_r]};
          default: pslverr_o <= 1'b1;
        endcase
      end
      if (wr) begin
        case (paddr_i)
          `SCIC_OFF_WAIT: wait_r <= pwdata_i;
          `SCIC_OFF_IRQ_MASK: irq_mask_r <= pwdata_i[`SCIC_IRQ_W-1:0];
          `SCIC_OFF_INSTR_IDX: iidx_r <= pwdata_i[IW-1:0];
          `SCIC_OFF_BUF_IDX: bidx_r <= pwdata_i[BW-1:0];
          default: ;
        endcase
      end
      // A new event wins over a write-one-to-clear in the same cycle
      irq_stat_r <= (irq_stat_r &
                     ~((wr && paddr_i == `SCIC_OFF_IRQ_STAT) ?
                       pwdata_i[`SCIC_IRQ_W-1:0] : {`SCIC_IRQ_W{1'b0}})) | irq_ev_r;
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule
